// *** verilog/acldam_pkg.sv ***
// package: constants, types and register map of the acl field matcher
package acldam_pkg;

    // =========================================================
    // widths
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam int IP_W = 32;
    localparam int OCT_W = 8;
    localparam int MAC_W = 48;
    localparam int OP_W = 16;
    localparam int CNT_W = 16;
    localparam int NUM_FLT = 4;

    // =========================================================
    // register map (byte addresses)
    localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [REG_AW-1:0] REG_FLT_BASE = 8'h04;
    localparam logic [REG_AW-1:0] FLT_STRIDE = 8'h08;
    localparam logic [REG_AW-1:0] FLT_MASK_OFS = 8'h04;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h24;
    localparam logic [REG_AW-1:0] REG_HITS = 8'h28;

    // filter slots, in register order
    localparam int FLT_DEST = 0;
    localparam int FLT_SRC = 1;
    localparam int FLT_SNDR = 2;
    localparam int FLT_TGT = 3;

    // =========================================================
    // control word fields
    localparam int CTRL_W = 16;
    localparam int CTRL_FT_LSB = 0;
    localparam int CTRL_FMODE_LSB = 2;
    localparam int CTRL_OPK_LSB = 10;
    localparam int CTRL_RR_LSB = 12;
    localparam int CTRL_SHA_LSB = 14;
    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h8000;

    // status word fields
    localparam int ST_MATCH = 0;
    localparam int ST_SEEN = 1;
    localparam int ST_FT_OK = 2;
    localparam int ST_IP_OK = 3;
    localparam int ST_ARP_OK = 4;

    // =========================================================
    // opcode_kind_select opcodes
    localparam logic [OP_W-1:0] OP_ARP_REQ = 16'h0001;
    localparam logic [OP_W-1:0] OP_ARP_REPLY = 16'h0002;
    localparam logic [OP_W-1:0] OP_RARP_REQ = 16'h0003;
    localparam logic [OP_W-1:0] OP_RARP_REPLY = 16'h0004;

    // =========================================================
    // modes
    typedef enum logic [1:0] {
        ADDR_ANY = 2'b00,
        ADDR_HOST = 2'b01,
        ADDR_NET = 2'b10
    } acldam_addr_mode_t;

    typedef enum logic [1:0] {
        FT_ANY = 2'b00,
        FT_IPV4 = 2'b01,
        FT_ARP = 2'b10
    } acldam_ftype_t;

    typedef enum logic [1:0] {
        OPK_ANY = 2'b00,
        OPK_ARP = 2'b01,
        OPK_RARP = 2'b10,
        OPK_OTHER = 2'b11
    } acldam_opkind_t;

    typedef enum logic [1:0] {
        RR_ANY = 2'b00,
        RR_REQ = 2'b01,
        RR_REPLY = 2'b10
    } acldam_reqrep_t;

    typedef enum logic [1:0] {
        SHA_DIFF = 2'b00,
        SHA_EQ = 2'b01,
        SHA_ANY = 2'b10
    } acldam_sha_t;

    // =========================================================
    // parsed frame fields from the ingress parser
    typedef struct packed {
        logic is_ipv4;
        logic is_arp;
        logic [IP_W-1:0] dest_ip;
        logic [IP_W-1:0] src_ip;
        logic [OP_W-1:0] arp_op;
        logic [IP_W-1:0] sender_ip;
        logic [IP_W-1:0] target_ip;
        logic [MAC_W-1:0] sender_hw;
        logic [MAC_W-1:0] src_mac;
    } acldam_frame_t;

endpackage : acldam_pkg

// *** verilog/acldam_addr_cmp.sv ***
// one ipv4 address filter: any, host or masked network compare
module acldam_addr_cmp
    import acldam_pkg::*;
(
    input wire logic [1:0] i_mode,
    input wire logic [IP_W-1:0] i_value,
    input wire logic [IP_W-1:0] i_mask,
    input wire logic [IP_W-1:0] i_field,
    output logic o_hit
);

    acldam_addr_mode_t mode;

    assign mode = acldam_addr_mode_t'(i_mode);

    always_comb
    begin
        unique case (mode)
            ADDR_ANY:
            begin
                o_hit = 1'b1;
            end
            ADDR_HOST:
            begin
                o_hit = (i_field == i_value);
            end
            ADDR_NET:
            begin
                o_hit = ((i_field ^ i_value) & i_mask) == '0;
            end
            default:
            begin
                // reserved code is read as don't-care
                o_hit = 1'b1;
            end
        endcase
    end

endmodule : acldam_addr_cmp

// *** verilog/acldam_matcher.sv ***
// access control entry matcher: ip address and arp field checks
// Contract
// - dest filter any ignores frame destination address.
// - dest host mode needs exact destination address equality.
// - dest network mode compares only bits set in dest mask.
// - addresses and masks are four octets forming one 32-bit word.
// - arp conditions apply only when entry frame type is arp.
// - opcode kind any, arp or rarp; match opcode of chosen protocol.
// - opcode kind other matches only unknown opcodes.
// - request setting matches arp or rarp request opcodes only.
// - reply setting matches reply opcodes; any ignores opcode.
// - sender filter any ignores arp sender address.
// - sender host needs equality; network compares masked bits.
// - target filter any ignores arp target address.
// - target host needs equality; network compares masked bits.
// - sha check 0 matches when sha differs from source mac.
// - sha check 1 matches when sha equals source mac.
// - sha check any leaves sha compare without effect.
// - source network uses address and mask; host uses address.
//
// The address-and-strobe port and the address map were left to the implementer.
module acldam_matcher
    import acldam_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [REG_AW-1:0] i_reg_addr,
    input wire logic [REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [REG_DW-1:0] o_reg_rdata,
    input wire logic i_frame_valid,
    input wire acldam_frame_t i_frame,
    output logic o_match_valid,
    output logic o_match
);

    // =========================================================
    // configuration storage
    logic [CTRL_W-1:0] ctrl_ff;
    logic [IP_W-1:0] flt_val_ff [NUM_FLT];
    logic [IP_W-1:0] flt_mask_ff [NUM_FLT];

    // =========================================================
    // result and status state
    logic match_valid_ff;
    logic match_ff;
    logic seen_ff;
    logic ft_ok_ff;
    logic ip_ok_ff;
    logic arp_ok_ff;
    logic [CNT_W-1:0] hits_ff;
    logic [CNT_W-1:0] nxt_hits;
    logic [REG_DW-1:0] rdata_ff;
    logic [REG_DW-1:0] nxt_rdata;

    // =========================================================
    // decoded settings
    acldam_ftype_t ftype;
    acldam_opkind_t opkind;
    acldam_reqrep_t reqrep;
    acldam_sha_t sha_mode;
    assign ftype = acldam_ftype_t'(ctrl_ff[CTRL_FT_LSB +: 2]);
    assign opkind = acldam_opkind_t'(ctrl_ff[CTRL_OPK_LSB +: 2]);
    assign reqrep = acldam_reqrep_t'(ctrl_ff[CTRL_RR_LSB +: 2]);
    assign sha_mode = acldam_sha_t'(ctrl_ff[CTRL_SHA_LSB +: 2]);

    // =========================================================
    // frame field per filter slot
    logic [IP_W-1:0] flt_field [NUM_FLT];
    logic [NUM_FLT-1:0] flt_hit;
    assign flt_field[FLT_DEST] = i_frame.dest_ip;
    assign flt_field[FLT_SRC] = i_frame.src_ip;
    assign flt_field[FLT_SNDR] = i_frame.sender_ip;
    assign flt_field[FLT_TGT] = i_frame.target_ip;

    // =========================================================
    // control register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            ctrl_ff <= CTRL_RST;
        end
        else if (i_reg_wr && (i_reg_addr == REG_CTRL))
        begin
            ctrl_ff <= i_reg_wdata[CTRL_W-1:0];
        end
    end

    // =========================================================
    // address filters: value, mask and compare per slot
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLT; gi++)
        begin : g_flt
            localparam logic [REG_AW-1:0] A_VAL =
                REG_AW'(REG_FLT_BASE + gi * FLT_STRIDE);
            localparam logic [REG_AW-1:0] A_MASK =
                REG_AW'(A_VAL + FLT_MASK_OFS);
            // whole 32-bit word holds the four octets
            always_ff @(posedge i_clk_sys)
            begin
                if (i_rst)
                begin
                    flt_val_ff[gi] <= '0;
                    flt_mask_ff[gi] <= '0;
                end
                else if (i_reg_wr && (i_reg_addr == A_VAL))
                begin
                    flt_val_ff[gi] <= i_reg_wdata[IP_W-1:0];
                end
                else if (i_reg_wr && (i_reg_addr == A_MASK))
                begin
                    flt_mask_ff[gi] <= i_reg_wdata[IP_W-1:0];
                end
            end
            // host uses value only, network uses value and mask
            acldam_addr_cmp u_cmp (
                .i_mode(ctrl_ff[CTRL_FMODE_LSB + 2 * gi +: 2]),
                .i_value(flt_val_ff[gi]),
                .i_mask(flt_mask_ff[gi]),
                .i_field(flt_field[gi]),
                .o_hit(flt_hit[gi])
            );
        end
    endgenerate

    // =========================================================
    // opcode classification
    logic op_is_arp;
    logic op_is_rarp;
    logic op_is_req;
    logic op_is_reply;
    assign op_is_arp = (i_frame.arp_op == OP_ARP_REQ)
        || (i_frame.arp_op == OP_ARP_REPLY);
    assign op_is_rarp = (i_frame.arp_op == OP_RARP_REQ)
        || (i_frame.arp_op == OP_RARP_REPLY);
    assign op_is_req = (i_frame.arp_op == OP_ARP_REQ)
        || (i_frame.arp_op == OP_RARP_REQ);
    assign op_is_reply = (i_frame.arp_op == OP_ARP_REPLY)
        || (i_frame.arp_op == OP_RARP_REPLY);

    // =========================================================
    // arp condition terms
    logic opk_ok;
    logic rr_ok;
    logic sha_ok;
    logic sha_same;
    assign sha_same = (i_frame.sender_hw == i_frame.src_mac);
    always_comb
    begin
        unique case (opkind)
            OPK_ANY:
            begin
                opk_ok = 1'b1;
            end
            OPK_ARP:
            begin
                opk_ok = op_is_arp;
            end
            OPK_RARP:
            begin
                opk_ok = op_is_rarp;
            end
            OPK_OTHER:
            begin
                opk_ok = !op_is_arp && !op_is_rarp;
            end
        endcase
    end

    always_comb
    begin
        unique case (reqrep)
            RR_ANY:
            begin
                rr_ok = 1'b1;
            end
            RR_REQ:
            begin
                rr_ok = op_is_req;
            end
            RR_REPLY:
            begin
                rr_ok = op_is_reply;
            end
            default:
            begin
                // reserved code is read as don't-care
                rr_ok = 1'b1;
            end
        endcase
    end

    always_comb
    begin
        unique case (sha_mode)
            SHA_DIFF:
            begin
                sha_ok = !sha_same;
            end
            SHA_EQ:
            begin
                sha_ok = sha_same;
            end
            SHA_ANY:
            begin
                sha_ok = 1'b1;
            end
            default:
            begin
                sha_ok = 1'b1;
            end
        endcase
    end

    // =========================================================
    // entry decision
    logic ft_ok;
    logic ip_ok;
    logic arp_ok;
    logic nxt_match;
    always_comb
    begin
        unique case (ftype)
            FT_ANY:
            begin
                ft_ok = 1'b1;
            end
            FT_IPV4:
            begin
                ft_ok = i_frame.is_ipv4;
            end
            FT_ARP:
            begin
                ft_ok = i_frame.is_arp;
            end
            default:
            begin
                // a reserved frame type never matches
                ft_ok = 1'b0;
            end
        endcase
    end

    // ip address filters only have meaning on ipv4 entries
    assign ip_ok = (ftype != FT_IPV4)
        || (flt_hit[FLT_DEST] && flt_hit[FLT_SRC]);
    assign arp_ok = (ftype != FT_ARP)
        || (opk_ok && rr_ok && sha_ok
            && flt_hit[FLT_SNDR]
            && flt_hit[FLT_TGT]);
    assign nxt_match = ft_ok && ip_ok && arp_ok;

    // =========================================================
    // registered result, one cycle after the frame fields
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            match_valid_ff <= 1'b0;
            match_ff <= 1'b0;
        end
        else
        begin
            match_valid_ff <= i_frame_valid;
            match_ff <= i_frame_valid && nxt_match;
        end
    end
    assign o_match_valid = match_valid_ff;
    assign o_match = match_ff;

    // =========================================================
    // status of the last evaluated frame
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            seen_ff <= 1'b0;
            ft_ok_ff <= 1'b0;
            ip_ok_ff <= 1'b0;
            arp_ok_ff <= 1'b0;
        end
        else if (i_frame_valid)
        begin
            seen_ff <= 1'b1;
            ft_ok_ff <= ft_ok;
            ip_ok_ff <= ip_ok;
            arp_ok_ff <= arp_ok;
        end
    end

    // =========================================================
    // hit counter: write clears, a hit in the same cycle survives
    always_comb
    begin
        nxt_hits = hits_ff;
        if (i_reg_wr && (i_reg_addr == REG_HITS))
        begin
            nxt_hits = '0;
        end
        // saturate so a busy port never wraps to a small count
        if (match_ff && (nxt_hits != '1))
        begin
            nxt_hits = CNT_W'(nxt_hits + 1'b1);
        end
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            hits_ff <= '0;
        end
        else
        begin
            hits_ff <= nxt_hits;
        end
    end

    // =========================================================
    // register read port, data one cycle after the strobe
    always_comb
    begin
        nxt_rdata = '0;
        if (i_reg_addr == REG_CTRL)
        begin
            nxt_rdata[CTRL_W-1:0] = ctrl_ff;
        end
        else if (i_reg_addr == REG_STATUS)
        begin
            nxt_rdata[ST_MATCH] = match_ff;
            nxt_rdata[ST_SEEN] = seen_ff;
            nxt_rdata[ST_FT_OK] = ft_ok_ff;
            nxt_rdata[ST_IP_OK] = ip_ok_ff;
            nxt_rdata[ST_ARP_OK] = arp_ok_ff;
        end
        else if (i_reg_addr == REG_HITS)
        begin
            nxt_rdata[CNT_W-1:0] = hits_ff;
        end
        else
        begin
            for (int k = 0; k < NUM_FLT; k++)
            begin
                if (i_reg_addr == REG_AW'(REG_FLT_BASE
                    + k * FLT_STRIDE))
                begin
                    nxt_rdata[IP_W-1:0] = flt_val_ff[k];
                end
                if (i_reg_addr == REG_AW'(REG_FLT_BASE
                    + k * FLT_STRIDE + FLT_MASK_OFS))
                begin
                    nxt_rdata[IP_W-1:0] = flt_mask_ff[k];
                end
            end
        end
    end
    // data stands only in the cycle after the read strobe
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !i_reg_rd)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign o_reg_rdata = rdata_ff;

endmodule : acldam_matcher

// *** test/acldam_matcher_properties.sv ***
// checker: timing and match-value properties of the acl matcher
module acldam_matcher_properties
    import acldam_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [REG_AW-1:0] i_reg_addr,
    input wire logic [REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [REG_DW-1:0] o_reg_rdata,
    input wire logic i_frame_valid,
    input wire acldam_frame_t i_frame,
    input wire logic o_match_valid,
    input wire logic o_match
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // shadow settings, so the expected result needs no peek inside
    logic [31:0] sh_ff [0:8];
    logic [15:0] c;
    logic [15:0] op;
    logic kn;
    logic opk_ok;
    logic ip_ok;
    logic arp_ok;
    logic exp_w;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < 9; i++)
                sh_ff[i] <= (i == 0) ? 32'h00008000 : 32'h00000000;
        end
        else if (i_reg_wr && i_reg_addr[1:0] == 2'h0 && i_reg_addr <= 8'h20)
            sh_ff[i_reg_addr[5:2]] <= i_reg_wdata;
    end

    function automatic logic hit(input logic [1:0] m, input logic [31:0] v,
        input logic [31:0] k, input logic [31:0] f);
        if (m == 2'h1)
            return f == v;
        return (m != 2'h2) || (((f ^ v) & k) == 32'h0);
    endfunction : hit

    always_comb
    begin
        c = sh_ff[0][15:0];
        op = i_frame.arp_op;
        kn = op >= 16'h1 && op <= 16'h4;
        opk_ok = c[11:10] == 2'h0 || (c[11:10] == 2'h1 && kn && op <= 16'h2)
            || (c[11:10] == 2'h2 && kn && op >= 16'h3)
            || (c[11:10] == 2'h3 && !kn);
        ip_ok = i_frame.is_ipv4 && hit(c[3:2], sh_ff[1], sh_ff[2],
            i_frame.dest_ip) && hit(c[5:4], sh_ff[3], sh_ff[4], i_frame.src_ip);
        arp_ok = i_frame.is_arp && opk_ok
            && (c[13:12] == 2'h0 || c[13:12] == 2'h3 || (kn && op[0] == c[12]))
            && (c[15] || ((i_frame.sender_hw == i_frame.src_mac) == c[14]))
            && hit(c[7:6], sh_ff[5], sh_ff[6], i_frame.sender_ip)
            && hit(c[9:8], sh_ff[7], sh_ff[8], i_frame.target_ip);
        exp_w = c[1:0] == 2'h0 || (c[1:0] == 2'h1 && ip_ok)
            || (c[1:0] == 2'h2 && arp_ok);
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    match_pulse_a: assert property (i_frame_valid |=> o_match_valid)
        else $error("no match valid one cycle after a frame");
    idle_quiet_a: assert property (!i_frame_valid |=> !o_match_valid && !o_match)
        else $error("match output without a frame");
    match_value_a: assert property (i_frame_valid |=> o_match == $past(exp_w))
        else $error("match result differs from the settings");
    dest_ignored_a: assert property (i_frame_valid && c[5:0] == 6'h01
        && i_frame.is_ipv4 |=> o_match)
        else $error("destination address not ignored in any mode");
    dest_host_a: assert property (i_frame_valid && c[3:0] == 4'h5
        && i_frame.dest_ip != sh_ff[1] |=> !o_match)
        else $error("host destination matched a different address");
    dest_net_a: assert property (i_frame_valid && c[3:0] == 4'h9
        && ((i_frame.dest_ip ^ sh_ff[1]) & sh_ff[2]) != 32'h0 |=> !o_match)
        else $error("network destination matched outside the mask");
    other_op_a: assert property (i_frame_valid && c[1:0] == 2'h2
        && c[11:10] == 2'h3 && kn |=> !o_match)
        else $error("other opcode kind matched a known opcode");
    sha_check_a: assert property (i_frame_valid && c[1:0] == 2'h2 && !c[15]
        && ((i_frame.sender_hw == i_frame.src_mac) != c[14]) |=> !o_match)
        else $error("sender hardware check ignored");
    rdata_idle_a: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0)
        else $error("read data outside the read answer cycle");
endmodule : acldam_matcher_properties

bind acldam_matcher acldam_matcher_properties i_acldam_matcher_properties (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .i_frame_valid(i_frame_valid),
    .i_frame(i_frame),
    .o_match_valid(o_match_valid),
    .o_match(o_match)
);

// *** test/acldam_pipe_model.sv ***
// partner: ingress parser feeding frames and policy logic taking results
module acldam_pipe_model
    import acldam_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_gap,
    output logic o_valid,
    output acldam_frame_t o_frame,
    input wire logic i_match_valid,
    input wire logic i_match
);
    timeunit 1ns;
    timeprecision 1ps;
    acldam_frame_t q [$];
    logic res [$];

    initial
    begin
        o_valid = 1'b0;
        o_frame = '0;
    end

    always @(posedge i_clk_sys)
    begin
        // with i_gap set the parser is slow: one idle cycle after each frame
        if (q.size() != 0 && !(i_gap && o_valid))
        begin
            o_valid <= 1'b1;
            o_frame <= q.pop_front();
        end
        else
        begin
            o_valid <= 1'b0;
            o_frame <= ~o_frame; // idle fields flip each cycle and hold the last frame on every second idle cycle
        end
        if (i_match_valid)
            res.push_back(i_match);
    end
endmodule : acldam_pipe_model

// *** test/acldam_matcher_tb_top.sv ***
// testbench: registers, match table and reset of the acl matcher
module acldam_matcher_tb_top
    import acldam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // cases: ty = {ipv4, arp}, dx flips address bits, he = {sha equal, hit}
    typedef struct packed {
        logic [15:0] ctrl;
        logic [1:0] ty;
        logic [15:0] dx;
        logic [3:0] op;
        logic [1:0] he;
    } acldam_case_t;
    localparam int NC = 41;
    localparam acldam_case_t CASES [NC] = '{
        '{16'h0001, 2'h2, 16'h1234, 4'h0, 2'h1},
        '{16'h0005, 2'h2, 16'h0000, 4'h0, 2'h1},
        '{16'h0005, 2'h2, 16'h0001, 4'h0, 2'h0},
        '{16'h0009, 2'h2, 16'h00FF, 4'h0, 2'h1},
        '{16'h0009, 2'h2, 16'h0100, 4'h0, 2'h0},
        '{16'h0021, 2'h2, 16'h0080, 4'h0, 2'h1},
        '{16'h0021, 2'h2, 16'h8000, 4'h0, 2'h0},
        '{16'h0011, 2'h2, 16'h0001, 4'h0, 2'h0},
        '{16'h0401, 2'h2, 16'h0000, 4'h7, 2'h1},
        '{16'h8002, 2'h2, 16'h0000, 4'h1, 2'h0},
        '{16'h8402, 2'h1, 16'h0000, 4'h2, 2'h1},
        '{16'h8402, 2'h1, 16'h0000, 4'h3, 2'h0},
        '{16'h8802, 2'h1, 16'h0000, 4'h4, 2'h1},
        '{16'h8802, 2'h1, 16'h0000, 4'h1, 2'h0},
        '{16'h8C02, 2'h1, 16'h0000, 4'h5, 2'h1},
        '{16'h8C02, 2'h1, 16'h0000, 4'h4, 2'h0},
        '{16'h9002, 2'h1, 16'h0000, 4'h3, 2'h1},
        '{16'h9002, 2'h1, 16'h0000, 4'h2, 2'h0},
        '{16'h9002, 2'h1, 16'h0000, 4'h6, 2'h0},
        '{16'hA002, 2'h1, 16'h0000, 4'h2, 2'h1},
        '{16'hA002, 2'h1, 16'h0000, 4'h3, 2'h0},
        '{16'h8002, 2'h1, 16'h0000, 4'h9, 2'h1},
        '{16'h8002, 2'h1, 16'hFFFF, 4'h1, 2'h1},
        '{16'h8042, 2'h1, 16'h0000, 4'h1, 2'h1},
        '{16'h8042, 2'h1, 16'h0001, 4'h1, 2'h0},
        '{16'h8082, 2'h1, 16'h00FF, 4'h1, 2'h1},
        '{16'h8082, 2'h1, 16'h0100, 4'h1, 2'h0},
        '{16'h8102, 2'h1, 16'h0000, 4'h1, 2'h1},
        '{16'h8102, 2'h1, 16'h0001, 4'h1, 2'h0},
        '{16'h8202, 2'h1, 16'h00FF, 4'h1, 2'h1},
        '{16'h8202, 2'h1, 16'h1000, 4'h1, 2'h0},
        '{16'h0002, 2'h1, 16'h0000, 4'h1, 2'h1},
        '{16'h0002, 2'h1, 16'h0000, 4'h1, 2'h2},
        '{16'h4002, 2'h1, 16'h0000, 4'h1, 2'h3},
        '{16'h4002, 2'h1, 16'h0000, 4'h1, 2'h0},
        '{16'h8002, 2'h1, 16'h0000, 4'h1, 2'h3},
        '{16'h4442, 2'h1, 16'h0000, 4'h1, 2'h3},
        '{16'h4442, 2'h1, 16'h0001, 4'h1, 2'h2},
        '{16'h003D, 2'h2, 16'hFFFF, 4'h0, 2'h1},
        '{16'hF0C2, 2'h1, 16'hFFFF, 4'h9, 2'h1},
        '{16'h0003, 2'h3, 16'h0000, 4'h1, 2'h0}
    };
    logic [31:0] vals [8] = '{32'h0A000005, 32'hFFFFFF00, 32'hC0A80101,
        32'hFFFFFF00, 32'h0A010203, 32'hFFFFFF00, 32'h0A0A0A0A, 32'hFFFFFF00};
    logic i_clk_sys;
    logic i_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic gap = 1'b0;
    logic [31:0] rdata;
    logic frame_valid;
    acldam_frame_t frame;
    logic match_valid;
    logic match;
    logic exq [$];
    logic [31:0] rv;
    int n_fail = 0;
    int compares = 0;
    int hits = 0;

    acldam_matcher i_acldam_matcher (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata),
        .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd),
        .o_reg_rdata(rdata),
        .i_frame_valid(frame_valid),
        .i_frame(frame),
        .o_match_valid(match_valid),
        .o_match(match)
    );
    acldam_pipe_model i_acldam_pipe_model (
        .i_clk_sys(i_clk_sys),
        .i_gap(gap),
        .o_valid(frame_valid),
        .o_frame(frame),
        .i_match_valid(match_valid),
        .i_match(match)
    );

    initial
    begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    // ==========================================================
    // tasks
    task automatic cmp(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        reg_rd <= 1'b0;
        @(negedge i_clk_sys);
        d = rdata;
    endtask : rd

    task automatic send(input acldam_case_t c);
        acldam_frame_t f;
        f = '0;
        f.is_ipv4 = c.ty[1];
        f.is_arp = c.ty[0];
        f.dest_ip = vals[0] ^ {16'h0, c.dx};
        f.src_ip = vals[2] ^ {16'h0, c.dx};
        f.sender_ip = vals[4] ^ {16'h0, c.dx};
        f.target_ip = vals[6] ^ {16'h0, c.dx};
        f.arp_op = {12'h000, c.op};
        f.sender_hw = 48'h0A1B2C3D4E5F;
        f.src_mac = c.he[1] ? f.sender_hw : ~f.sender_hw;
        @(negedge i_clk_sys);
        i_acldam_pipe_model.q.push_back(f);
        exq.push_back(c.he[0]);
        hits += int'(c.he[0]);
    endtask : send

    task automatic drain();
        int k;
        k = 0;
        while (i_acldam_pipe_model.res.size() < exq.size() && k < 400)
        begin
            @(posedge i_clk_sys);
            k++;
        end
        cmp("result count", i_acldam_pipe_model.res.size(), exq.size());
        while (exq.size() != 0 && i_acldam_pipe_model.res.size() != 0)
            cmp("match", i_acldam_pipe_model.res.pop_front(), exq.pop_front());
    endtask : drain

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // ==========================================================
    // watchdog: the whole sequence needs well under 2000 cycles
    initial
    begin
        #(8 * 20000);
        n_fail++;
        end_sim();
    end

    initial
    begin
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            rd(8'(i * 4), rv);
            cmp("reset value", rv, (i == 0) ? 32'h8000 : 32'h0);
        end
        for (int i = 0; i < 8; i++)
            wr(8'(i * 4 + 4), vals[i]);
        wr(8'h24, 32'h1F);
        wr(8'h30, 32'hFFFF);
        for (int i = 0; i < 8; i++)
        begin
            rd(8'(i * 4 + 4), rv);
            cmp("address setting", rv, vals[i]);
        end
        rd(8'h24, rv);
        cmp("status read only", rv, 32'h0);
        for (int i = 0; i < NC; i++)
        begin
            wr(8'h00, {16'h0, CASES[i].ctrl});
            send(CASES[i]);
        end
        drain();
        // frames back to back, then with the parser running slow
        for (int g = 0; g < 2; g++)
        begin
            gap <= g[0];
            wr(8'h00, 32'h8C02);
            for (int op = 0; op < 6; op++)
                send(acldam_case_t'{16'h8C02, 2'h1, 16'h0, 4'(op),
                    {1'b1, op == 0 || op == 5}});
            drain();
        end
        rd(8'h28, rv);
        cmp("hit count", rv, 32'(hits));
        rd(8'h24, rv);
        cmp("status", rv, 32'h1E);
        wr(8'h28, 32'h0);
        rd(8'h28, rv);
        cmp("hit clear", rv, 32'h0);
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(8'h00, rv);
        cmp("control after reset", rv, 32'h8000);
        rd(8'h04, rv);
        cmp("address after reset", rv, 32'h0);
        end_sim();
    end
endmodule : acldam_matcher_tb_top
